// *** hdl/usb_rx_dma_pkg.sv ***
/*
  shared constants and types of the receive descriptor dma engine.
  assumes 32-bit processor memory and an 8-bit register address space.
*/
package usb_rx_dma_pkg;

  localparam int NUM_CH   = 4;  // receive channels
  localparam int CH_W     = 2;  // channel number width
  localparam int LEN_W    = 16; // byte length fields

  // register map, byte addresses and channel state word numbers
  localparam logic [7:0] REG_CH_AREA_END = 8'h80; // below: channel words
  localparam logic [2:0] REG_W_OFFSET    = 3'h0;  // state word 0: offset
  localparam logic [2:0] REG_W_HEAD      = 3'h1;  // head descriptor ptr
  localparam logic [2:0] REG_W_SOP       = 3'h2;  // sop descriptor ptr
  localparam logic [2:0] REG_W_CUR       = 3'h3;  // current descriptor
  localparam logic [2:0] REG_W_BUFP      = 3'h4;  // current buffer ptr
  localparam logic [2:0] REG_W_LENS      = 3'h5;  // packet and buffer count
  localparam logic [2:0] REG_W_COMP      = 3'h7;  // completion pointer
  localparam logic [7:0] REG_CTRL        = 8'h80; // port/dma/aggregation
  localparam logic [7:0] REG_BUFCNT0     = 8'h84; // buffer count, ch 0
  localparam logic [7:0] REG_MPS         = 8'h94; // max packet size
  localparam logic [7:0] REG_STATUS      = 8'h98; // engine state, irqs

  // control register fields
  localparam int CTRL_PORT_EN_BIT = 0;
  localparam int CTRL_DMA_EN_LSB  = 4;
  localparam int CTRL_AGG_LSB     = 8;

  // descriptor word offsets and flag positions
  localparam logic [31:0] DESC_NEXT = 32'h0000_0000;
  localparam logic [31:0] DESC_BUF  = 32'h0000_0004;
  localparam logic [31:0] DESC_LEN  = 32'h0000_0008;
  localparam logic [31:0] DESC_FLAG = 32'h0000_000c;
  localparam int FLAG_SOP_BIT   = 31;
  localparam int FLAG_EOP_BIT   = 30;
  localparam int FLAG_OWN_BIT   = 29;
  localparam int FLAG_EOQ_BIT   = 28;
  localparam int FLAG_ABORT_BIT = 26;
  localparam int FLAG_ZERO_BIT  = 23;

  localparam logic [7:0]       MIN_BUFS    = 8'h03;  // start threshold
  localparam logic [LEN_W-1:0] MPS_RESET   = 16'h0040;
  localparam logic [31:0]      NULL_PTR    = 32'h0000_0000;

  // memory master request
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } mem_req_t;

  // endpoint fifo byte presented to the engine
  typedef struct packed {
    logic            valid;
    logic [CH_W-1:0] ch;
    logic [7:0]      data;
    logic            last;  // last byte of a usb packet
    logic            zlp;   // zero length usb packet marker, no data
  } ep_in_t;

  typedef enum logic [3:0] {
    S_IDLE       = 4'b0000,
    S_FETCH_NEXT = 4'b0001,
    S_FETCH_BUF  = 4'b0010,
    S_FETCH_LEN  = 4'b0011,
    S_DATA       = 4'b0100,
    S_POP        = 4'b0101,
    S_WB_FULL    = 4'b0110,
    S_DROP       = 4'b0111,
    S_LAST_LEN   = 4'b1000,
    S_LAST_FLAG  = 4'b1001,
    S_SOP_LEN    = 4'b1010,
    S_SOP_FLAG   = 4'b1011,
    S_DONE       = 4'b1100
  } eng_state_t;

endpackage

// *** hdl/usb_rx_chan_state.sv ***
/*
  per-channel receive state: buffer offset, head descriptor pointer,
  completion pointer, buffer count and completion interrupt.
  assumes register strokes and engine pulses on the same clock.
*/
`timescale 1ns/1ns
module usb_rx_chan_state
  import usb_rx_dma_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             sw_wr,       // write to a state word
  input  wire logic [2:0]       sw_word,     // which state word
  input  wire logic             sw_cnt_wr,   // write to buffer count
  input  wire logic [31:0]      sw_wdata,
  input  wire logic             eng_done,    // packet finished
  input  wire logic             eng_consume, // one buffer used
  input  wire logic [31:0]      eng_last,    // last descriptor of packet
  input  wire logic [31:0]      eng_next,    // link after last descriptor
  output logic      [LEN_W-1:0] offset_q,
  output logic      [31:0]      head_q,
  output logic      [31:0]      comp_q,
  output logic      [7:0]       bufcnt_q,
  output logic                  irq_q
);

  // engine's own last address, apart from the software-written copy
  logic [31:0] dev_q;

  wire head_wr = sw_wr && (sw_word == REG_W_HEAD);
  wire comp_wr = sw_wr && (sw_word == REG_W_COMP);
  wire offs_wr = sw_wr && (sw_word == REG_W_OFFSET);
  // acknowledge only lands on an exact match
  // a wrong ack must not move the value that a later ack is held to
  wire ack_ok  = comp_wr && (sw_wdata == dev_q);

  // offset and head pointer; software write wins over engine advance
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      offset_q <= '0;
      head_q   <= NULL_PTR;
    end else begin
      if (offs_wr) begin
        offset_q <= sw_wdata[LEN_W-1:0];
      end
      if (head_wr) begin
        head_q <= sw_wdata;
      end else if (eng_done) begin
        head_q <= eng_next;
      end
    end
  end

  // completion pointer and interrupt; a new completion beats a clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      comp_q <= NULL_PTR;
      dev_q  <= NULL_PTR;
      irq_q  <= 1'b0;
    end else begin
      if (eng_done) begin
        comp_q <= eng_last;
        dev_q  <= eng_last;
        irq_q  <= 1'b1;
      end else if (comp_wr) begin
        comp_q <= sw_wdata;
        irq_q  <= irq_q && !ack_ok;
      end
    end
  end

  // buffer count; a consume in the write cycle is still charged
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bufcnt_q <= '0;
    end else if (sw_cnt_wr) begin
      bufcnt_q <= sw_wdata[7:0] - {7'h00, eng_consume};
    end else if (eng_consume && (bufcnt_q != 8'h00)) begin
      bufcnt_q <= bufcnt_q - 8'h01;
    end
  end

endmodule

// *** hdl/usb_rx_descriptor_dma.sv ***
/*
  receive descriptor dma: moves endpoint fifo bytes into linked buffer
  descriptors in processor memory for four channels, writes back
  lengths and flags, and reports completion per channel.
  assumes a memory slave that pulses mem_ack once per request, and an
  endpoint fifo that holds a byte stable until ep_ready is seen.
*/
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ns

// Notes on behaviour
// - no new transfer below three buffers
// - each consumed buffer decrements the count
// - nonzero head pointer write enables reception
// - buffers filled in queue link order
// - skip buffer offset bytes in first buffer
// - last descriptor length becomes bytes received
// - last descriptor gets end flag, queue-end flag; queue-end is set only when its link is null
// - first descriptor gets offset, length, flags, ownership
// - completion pointer write raises channel interrupt
// - matching acknowledge clears interrupt, mismatch keeps it
// - packet at queue end overruns and drops
// - abort flag marks packets cut short
// - transparent mode ends packet per usb packet
// - aggregation mode merges full packets until short
// - exact multiple waits for zero length packet
// - ownership one means device owns packet
// - zero length packet sets zero-byte flag when the dma packet holds no bytes
// - four channels, each with own interrupt
module usb_rx_descriptor_dma
  import usb_rx_dma_pkg::*;
#(
  parameter int CHANNELS = NUM_CH
)(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output mem_req_t         mem_o,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  input  wire ep_in_t      ep_i,
  output logic             ep_ready,
  output logic [CHANNELS-1:0] rx_irq
);

  // the map and channel field are sized for exactly four channels
  if (CHANNELS != NUM_CH) begin : g_bad_channels
    $error("usb_rx_descriptor_dma supports exactly four channels");
  end

  // software visible control
  logic [31:0]      ctrl_q;   // port enable, dma enables, aggregation
  logic [LEN_W-1:0] mps_q;    // endpoint max packet size

  // engine state
  eng_state_t       state_q;
  logic [CH_W-1:0]  ch_q;      // channel being served
  logic [31:0]      sop_q;     // first descriptor of packet
  logic [31:0]      cur_q;     // descriptor being filled
  logic [31:0]      next_q;    // link of current descriptor
  logic [31:0]      bufp_q;    // buffer pointer of current descriptor
  logic [LEN_W-1:0] blen_q;    // buffer size of current descriptor
  logic [LEN_W-1:0] cnt_q;     // bytes in current buffer
  logic [LEN_W-1:0] pkt_q;     // bytes in dma packet
  logic [LEN_W-1:0] usb_q;     // bytes in current usb packet
  logic [LEN_W-1:0] sop_len_q; // bytes kept in first buffer
  logic             zlp_q;     // usb packet was zero length
  logic             zero_q;    // whole dma packet empty
  logic             abort_q;   // cut short for lack of buffers
  logic             drop_q;    // discarding fifo bytes
  logic             last_q;    // popped byte closed a usb packet
  logic             done_q;    // completion pulse to channel
  logic             consume_q; // buffer-used pulse to channel
  mem_req_t         mem_q;
  logic             ready_q;
  logic [31:0]      rd_q;

  // per-channel state, one instance each
  logic [LEN_W-1:0] ch_off    [CHANNELS];
  logic [31:0]      ch_head   [CHANNELS];
  logic [31:0]      ch_comp   [CHANNELS];
  logic [7:0]       ch_cnt    [CHANNELS];
  logic [CHANNELS-1:0] ch_irq;

  wire              ch_area = reg_addr < REG_CH_AREA_END;
  wire [CH_W-1:0]   reg_ch  = reg_addr[6:5];
  wire [2:0]        reg_wd  = reg_addr[4:2];

  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    localparam logic [7:0] CNT_ADDR = REG_BUFCNT0 + 8'(4 * c);
    usb_rx_chan_state u_state (
      .core_clk    (core_clk),
      .arst_n      (arst_n),
      .sw_wr       (reg_wr && ch_area && (reg_ch == CH_W'(c))),
      .sw_word     (reg_wd),
      .sw_cnt_wr   (reg_wr && (reg_addr == CNT_ADDR)),
      .sw_wdata    (reg_wdata),
      .eng_done    (done_q && (ch_q == CH_W'(c))),
      .eng_consume (consume_q && (ch_q == CH_W'(c))),
      .eng_last    (cur_q),
      .eng_next    (next_q),
      .offset_q    (ch_off[c]),
      .head_q      (ch_head[c]),
      .comp_q      (ch_comp[c]),
      .bufcnt_q    (ch_cnt[c]),
      .irq_q       (ch_irq[c])
    );
  end

  // start decision for the channel the fifo offers
  wire        port_en  = ctrl_q[CTRL_PORT_EN_BIT];
  wire        dma_en   = ctrl_q[CTRL_DMA_EN_LSB + 32'(ep_i.ch)];
  wire        agg_en   = ctrl_q[CTRL_AGG_LSB + 32'(ch_q)];
  wire [31:0] in_head  = ch_head[ep_i.ch];
  wire        offered  = ep_i.valid && port_en && dma_en && !done_q;
  wire        start_ok = offered && (in_head != NULL_PTR)
                         && (ch_cnt[ep_i.ch] >= MIN_BUFS);
  wire        ovr_sop  = offered && (in_head == NULL_PTR);

  // offset applies only in first buffer
  wire              at_sop   = (cur_q == sop_q);
  wire [LEN_W-1:0]  skip     = at_sop ? ch_off[ch_q] : '0;
  wire [LEN_W-1:0]  cap      = blen_q - skip;
  wire              full     = (cnt_q == cap);
  wire [31:0]       byte_a   = bufp_q + {16'h0000, skip} + {16'h0000, cnt_q};
  wire              queue_end_flag      = (next_q == NULL_PTR);
  // first descriptor status word, ownership cleared
  wire [31:0]       sop_word = (32'h1 << FLAG_SOP_BIT)
                             | (32'(abort_q) << FLAG_ABORT_BIT)
                             | (32'(zero_q) << FLAG_ZERO_BIT)
                             | {16'h0000, pkt_q};
  // end flag, queue-end flag on null link
  wire [31:0]       eop_word = (32'h1 << FLAG_EOP_BIT)
                             | (32'(queue_end_flag) << FLAG_EOQ_BIT)
                             | (at_sop ? sop_word : 32'h0);
  wire              usb_short = (usb_q < mps_q);

  // memory access wanted in the present state
  wire data_wr = (state_q == S_DATA) && ep_i.valid && !ep_i.zlp && !full;
  wire mem_state = data_wr || (state_q == S_FETCH_NEXT)
                 || (state_q == S_FETCH_BUF) || (state_q == S_FETCH_LEN)
                 || (state_q == S_WB_FULL) || (state_q == S_LAST_LEN)
                 || (state_q == S_LAST_FLAG) || (state_q == S_SOP_LEN)
                 || (state_q == S_SOP_FLAG);
  mem_req_t acc;

  // address and data of the access for each state
  always_comb begin
    acc       = '0;
    acc.req   = 1'b1;
    acc.we    = 1'b1;
    acc.be    = 4'hf;
    case (state_q)
      S_FETCH_NEXT: begin
        acc.we   = 1'b0;
        acc.addr = cur_q + DESC_NEXT;
      end
      S_FETCH_BUF: begin
        acc.we   = 1'b0;
        acc.addr = cur_q + DESC_BUF;
      end
      S_FETCH_LEN: begin
        acc.we   = 1'b0;
        acc.addr = cur_q + DESC_LEN;
      end
      S_DATA: begin
        // one byte lane, data copied to all lanes
        acc.addr  = {byte_a[31:2], 2'b00};
        acc.wdata = {4{ep_i.data}};
        acc.be    = 4'h1 << byte_a[1:0];
      end
      S_WB_FULL, S_LAST_LEN: begin
        acc.addr  = cur_q + DESC_LEN;
        acc.wdata = {skip, cnt_q};
      end
      S_LAST_FLAG: begin
        acc.addr  = cur_q + DESC_FLAG;
        acc.wdata = eop_word;
      end
      S_SOP_LEN: begin
        acc.addr  = sop_q + DESC_LEN;
        acc.wdata = {ch_off[ch_q], sop_len_q};
      end
      S_SOP_FLAG: begin
        acc.addr  = sop_q + DESC_FLAG;
        acc.wdata = sop_word;
      end
      default: begin
        acc.req = 1'b0;
      end
    endcase
  end

  // memory request holds until acknowledged
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_q <= '0;
    end else if (mem_ack) begin
      mem_q.req <= 1'b0;
    end else if (mem_state && !mem_q.req) begin
      mem_q <= acc;
    end
  end

  // engine sequence
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
      ch_q <= '0;       sop_q <= NULL_PTR;  cur_q <= NULL_PTR;
      next_q <= NULL_PTR; bufp_q <= NULL_PTR; blen_q <= '0;
      cnt_q <= '0;      pkt_q <= '0;        usb_q <= '0;
      sop_len_q <= '0;  zlp_q <= 1'b0;      zero_q <= 1'b0;
      abort_q <= 1'b0;  drop_q <= 1'b0;     last_q <= 1'b0;
      done_q <= 1'b0;   consume_q <= 1'b0;  ready_q <= 1'b0;
    end else begin
      done_q    <= 1'b0;
      consume_q <= 1'b0;
      ready_q   <= 1'b0;
      case (state_q)
        S_IDLE: begin
          ch_q <= ep_i.ch;
          cnt_q <= '0; pkt_q <= '0; usb_q <= '0;
          zlp_q <= 1'b0; zero_q <= 1'b0; abort_q <= 1'b0;
          last_q <= 1'b0;
          if (start_ok) begin
            sop_q   <= in_head;
            cur_q   <= in_head;
            drop_q  <= 1'b0;
            state_q <= S_FETCH_NEXT;
          end else if (ovr_sop) begin
            drop_q  <= 1'b1;
            state_q <= S_DROP;
          end
        end
        S_FETCH_NEXT: if (mem_ack) begin
          next_q  <= mem_rdata;
          state_q <= S_FETCH_BUF;
        end
        S_FETCH_BUF: if (mem_ack) begin
          bufp_q  <= mem_rdata;
          state_q <= S_FETCH_LEN;
        end
        S_FETCH_LEN: if (mem_ack) begin
          blen_q  <= mem_rdata[LEN_W-1:0];
          cnt_q   <= '0;
          state_q <= S_DATA;
        end
        S_DATA: begin
          if (ep_i.valid && ep_i.zlp) begin
            ready_q <= 1'b1;
            zlp_q   <= 1'b1;
            last_q  <= 1'b1;
            state_q <= S_POP;
          end else if (ep_i.valid && full) begin
            state_q <= S_WB_FULL;
          end else if (mem_ack) begin
            cnt_q   <= cnt_q + 16'h0001;
            pkt_q   <= pkt_q + 16'h0001;
            usb_q   <= usb_q + 16'h0001;
            ready_q <= 1'b1;
            last_q  <= ep_i.last;
            state_q <= S_POP;
          end
        end
        // fifo sees ready here; the byte is gone next cycle
        S_POP: begin
          last_q <= 1'b0;
          zlp_q  <= 1'b0;
          if (drop_q) begin
            state_q <= !last_q ? S_DROP
                       : (abort_q ? S_LAST_LEN : S_IDLE);
          end else if (last_q && (!agg_en || zlp_q || usb_short)) begin
            zero_q  <= (pkt_q == '0);
            state_q <= S_LAST_LEN;
          end else begin
            if (last_q) begin
              usb_q <= '0;
            end
            state_q <= S_DATA;
          end
        end
        S_WB_FULL: if (mem_ack) begin
          if (at_sop) begin
            sop_len_q <= cnt_q;
          end
          if (queue_end_flag) begin
            abort_q <= 1'b1;
            drop_q  <= 1'b1;
            state_q <= S_DROP;
          end else begin
            consume_q <= 1'b1;
            cur_q     <= next_q;
            state_q   <= S_FETCH_NEXT;
          end
        end
        S_DROP: if (ep_i.valid) begin
          ready_q <= 1'b1;
          last_q  <= ep_i.last || ep_i.zlp;
          state_q <= S_POP;
        end
        S_LAST_LEN: if (mem_ack) begin
          if (at_sop) begin
            sop_len_q <= cnt_q;
          end
          state_q <= S_LAST_FLAG;
        end
        S_LAST_FLAG: if (mem_ack) begin
          state_q <= at_sop ? S_DONE : S_SOP_LEN;
        end
        S_SOP_LEN: if (mem_ack) begin
          state_q <= S_SOP_FLAG;
        end
        S_SOP_FLAG: if (mem_ack) begin
          state_q <= S_DONE;
        end
        S_DONE: begin
          done_q    <= 1'b1;
          consume_q <= 1'b1;
          drop_q    <= 1'b0;
          state_q   <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // register writes to global control
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= '0;
      mps_q  <= MPS_RESET;
    end else if (reg_wr && (reg_addr == REG_CTRL)) begin
      ctrl_q <= reg_wdata;
    end else if (reg_wr && (reg_addr == REG_MPS)) begin
      mps_q  <= reg_wdata[LEN_W-1:0];
    end
  end

  // read selection; engine words show the live engine state
  logic [31:0] rd_sel;
  wire         cnt_area = (reg_addr >= REG_BUFCNT0) && (reg_addr < REG_MPS);
  wire [CH_W-1:0] cnt_ch = CH_W'((reg_addr - REG_BUFCNT0) >> 2);
  always_comb begin
    rd_sel = 32'h0000_0000;
    if (ch_area) begin
      case (reg_wd)
        REG_W_OFFSET: rd_sel = {16'h0000, ch_off[reg_ch]};
        REG_W_HEAD:   rd_sel = ch_head[reg_ch];
        REG_W_SOP:    rd_sel = (reg_ch == ch_q) ? sop_q : NULL_PTR;
        REG_W_CUR:    rd_sel = (reg_ch == ch_q) ? cur_q : NULL_PTR;
        REG_W_BUFP:   rd_sel = (reg_ch == ch_q) ? bufp_q : NULL_PTR;
        REG_W_LENS:   rd_sel = (reg_ch == ch_q) ? {pkt_q, cnt_q} : '0;
        REG_W_COMP:   rd_sel = ch_comp[reg_ch];
        default:      rd_sel = 32'h0000_0000;
      endcase
    end else if (cnt_area && (reg_addr[1:0] == 2'b00)) begin
      rd_sel = {24'h000000, ch_cnt[cnt_ch]};
    end else if (reg_addr == REG_CTRL) begin
      rd_sel = ctrl_q;
    end else if (reg_addr == REG_MPS) begin
      rd_sel = {16'h0000, mps_q};
    end else if (reg_addr == REG_STATUS) begin
      rd_sel = {20'h00000, state_q, 2'b00, ch_q, ch_irq};
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q   <= '0;
      rx_irq <= '0;
    end else begin
      rd_q   <= reg_rd ? rd_sel : 32'h0000_0000;
      rx_irq <= ch_irq;
    end
  end

  assign reg_rdata = rd_q;
  assign mem_o     = mem_q;
  assign ep_ready  = ready_q;

endmodule

// *** verification/usb_rx_mem_model.sv ***
/*
  memory slave model: word store, one ack per request.
  assumes one request at a time, held until its ack.
*/
`timescale 1ns/1ns
module usb_rx_mem_model
  import usb_rx_dma_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     arst_n,
  input  wire mem_req_t mem_i,
  output logic          mem_ack,
  output logic [31:0]   mem_rdata
);
  logic [31:0] mem [0:255]; // 1 KiB store, bench preloads it
  logic [1:0]  dly_q;       // wait left before next ack
  logic        slow_q;      // alternate prompt and slow answers
  // idle read data toggles so a stale word never looks valid
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack <= 1'b0;
      dly_q <= 2'd0;
      slow_q <= 1'b0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_i.req && !mem_ack && dly_q != 2'd0) begin
        dly_q <= dly_q - 2'd1;
      end else if (mem_i.req && !mem_ack) begin
        mem_ack <= 1'b1;
        slow_q <= !slow_q;
        dly_q <= slow_q ? 2'd0 : 2'd3;
        if (!mem_i.we) mem_rdata <= mem[mem_i.addr[9:2]];
        for (int i = 0; i < 4; i++)
          if (mem_i.we && mem_i.be[i])
            mem[mem_i.addr[9:2]][8*i +: 8] <= mem_i.wdata[8*i +: 8];
      end
    end
  end
endmodule

// *** verification/usb_rx_dma_chk.sv ***
/*
  port assertions of the rx descriptor dma.
  assumes one clock domain and the async reset.
*/
`timescale 1ns/1ns
module usb_rx_dma_chk
  import usb_rx_dma_pkg::*;
#(parameter int CHANNELS = NUM_CH)(
  input wire logic                core_clk,
  input wire logic                arst_n,
  input wire logic [7:0]          reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata,
  input wire mem_req_t            mem_o,
  input wire logic                mem_ack,
  input wire logic [31:0]         mem_rdata,
  input wire ep_in_t              ep_i,
  input wire logic                ep_ready,
  input wire logic [CHANNELS-1:0] rx_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [3:0] age_q; // cycles since last flag word write
  // saturates, so an old write never counts as fresh
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) age_q <= 4'hf;
    else if (mem_ack && mem_o.we && mem_o.addr[3:0] == 4'hc) age_q <= 4'h0;
    else if (age_q != 4'hf) age_q <= age_q + 4'h1;
  end
  chk_req_hold: assert property (mem_o.req && !mem_ack |=>
    mem_o.req && $stable(mem_o)) else $error("request moved");
  chk_req_drop: assert property (mem_ack |=> !mem_o.req)
    else $error("request kept");
  chk_irq_cause: assert property ($rose(|rx_irq) |->
    age_q < 4'h6) else $error("irq without flag write");
  chk_pop_gap: assert property (ep_ready |=> !ep_ready)
    else $error("pops too close");
  chk_pop_valid: assert property (ep_ready |-> $past(ep_i.valid))
    else $error("pop without byte");
  chk_rd_align: assert property (mem_o.req && !mem_o.we |->
    mem_o.addr[1:0] == 2'b00) else $error("unaligned read");
  chk_lane_sel: assert property (mem_o.req && mem_o.we &&
    mem_o.be != 4'hf |-> $onehot(mem_o.be) && mem_o.addr[1:0] == 2'b00)
    else $error("bad byte lane");
  chk_own_clear: assert property (mem_o.req && mem_o.we &&
    mem_o.be == 4'hf && mem_o.addr[3:0] == 4'hc |->
    !mem_o.wdata[FLAG_OWN_BIT]) else $error("ownership kept");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 0)
    else $error("read data outside slot");
  cover property ($rose(rx_irq[0]));
  cover property (ep_ready && ep_i.zlp);
  cover property (mem_ack && mem_o.we && mem_o.be != 4'hf);
endmodule
bind usb_rx_descriptor_dma usb_rx_dma_chk #(.CHANNELS(CHANNELS)) chk_u (
  .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .mem_o(mem_o), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .ep_i(ep_i), .ep_ready(ep_ready),
  .rx_irq(rx_irq));

// *** verification/usb_rx_descriptor_dma_test.sv ***
/*
  bench: channel 0 traffic into a three descriptor queue.
  assumes the memory model answers on the memory port.
*/
`timescale 1ns/1ns
module usb_rx_descriptor_dma_test
  import usb_rx_dma_pkg::*;
;
  logic       core_clk, arst_n, reg_wr, reg_rd, mem_ack, ep_ready;
  logic [7:0] reg_addr, q[$]; // q: expected packet bytes
  logic [31:0] reg_wdata, reg_rdata, mem_rdata;
  logic [3:0] rx_irq;
  mem_req_t   mem_o;
  ep_in_t     ep_i;
  int         miscompares = 0, checks_done = 0, cyc = 0;
  always #25 core_clk = ~core_clk;
  usb_rx_descriptor_dma dut_u (.core_clk(core_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_o(mem_o),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ep_i(ep_i),
    .ep_ready(ep_ready), .rx_irq(rx_irq));
  usb_rx_mem_model mem_u (.core_clk(core_clk), .arst_n(arst_n),
    .mem_i(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read slot is the cycle after the strobe, sampled at its end
  task automatic rdc(logic [7:0] a, logic [31:0] e, string n);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    chk(n, e, reg_rdata);
  endtask
  task automatic put(logic l, logic z);
    logic [7:0] b;
    b = 8'($urandom);
    if (!z) q.push_back(b);
    @(posedge core_clk);
    ep_i <= '{1'b1, 2'd0, b, l, z};
  endtask
  task automatic pop;
    int n;
    n = 0;
    do @(posedge core_clk); while (ep_ready !== 1'b1 && ++n < 300);
    chk("pop", 1, ep_ready);
    ep_i.valid <= 1'b0;
    ep_i.data <= ~ep_i.data;
  endtask
  task automatic pkt(int n);
    for (int i = 0; i < n; i++) begin
      put(i == n - 1, 1'b0);
      pop;
    end
  endtask
  task automatic wirq(logic e);
    int n;
    n = 0;
    do @(posedge core_clk); while (rx_irq[0] !== e && ++n < 500);
    chk("irq", e, rx_irq[0]);
  endtask
  task automatic bytes(int base);
    foreach (q[i])
      chk("byte", q[i], mem_u.mem[(base+i)/4][8*((base+i)%4) +: 8]);
    q.delete();
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard, far above the run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test;
    end
  end
  initial begin
    {core_clk, arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    ep_i = '0;
    void'($urandom(32'hc26a));
    for (int i = 0; i < 3; i++) begin
      mem_u.mem[64+4*i] = i < 2 ? 32'h110 + 16*i : 0;
      mem_u.mem[65+4*i] = 32'h200 + 16*i;
      mem_u.mem[66+4*i] = i < 2 ? 32'h8 : 32'h40;
      mem_u.mem[67+4*i] = 32'h2000_0000;
    end
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 28; i++) wr(8'((i / 7) * 32 + (i % 7) * 4), 0);
    wr(REG_CTRL, 32'h11);
    wr(REG_MPS, 32'h8);
    wr(8'h00, 32'h1);
    wr(REG_BUFCNT0, 32'h3);
    wr(8'h04, 32'h100);
    pkt(3);
    wirq(1);
    bytes(32'h201);
    chk("len0", 32'h0001_0003, mem_u.mem[66]);
    chk("flag0", 32'hc000_0003, mem_u.mem[67]);
    rdc(8'h1c, 32'h100, "comp0");
    rdc(REG_BUFCNT0, 32'h2, "bufcnt");
    wr(8'h1c, 32'h110);
    repeat (3) @(posedge core_clk);
    chk("irq kept", 1, rx_irq[0]);
    wr(8'h1c, 32'h100);
    wirq(0);
    $display("test transparent done");
    wr(8'h00, 0);
    wr(REG_BUFCNT0, 32'h2);
    put(1'b1, 1'b0);
    repeat (20) begin
      @(posedge core_clk);
      chk("gated", 0, ep_ready);
    end
    wr(REG_BUFCNT0, 32'h3);
    pop;
    wirq(1);
    bytes(32'h210);
    chk("flag1", 32'hc000_0001, mem_u.mem[71]);
    wr(8'h1c, 32'h110);
    wirq(0);
    $display("test gating done");
    wr(REG_CTRL, 32'h111);
    wr(REG_MPS, 32'h40);
    wr(REG_BUFCNT0, 32'h3);
    pkt(64);
    repeat (10) begin
      @(posedge core_clk);
      chk("agg hold", 0, rx_irq[0]);
    end
    put(1'b1, 1'b1);
    pop;
    wirq(1);
    bytes(32'h220);
    chk("len2", 32'h40, mem_u.mem[74]);
    chk("flag2", 32'hd000_0040, mem_u.mem[75]);
    rdc(8'h1c, 32'h120, "comp2");
    chk("own2", 0, mem_u.mem[75][FLAG_OWN_BIT]);
    chk("link2", 0, mem_u.mem[72]);
    chk("irq idle", 0, rx_irq[3:1]);
    mem_u.mem[72] = 32'h100; // buffer added after queue end
    wr(8'h04, 32'h100);
    rdc(8'h04, 32'h100, "rearm");
    $display("test aggregation done");
    end_of_test;
  end
endmodule
